// ==== core/ifm_cfg.svh ====
// offsets, field positions, reset values of the input function mapper
`ifndef IFM_CFG_SVH
`define IFM_CFG_SVH

`define IFM_NUM_TERM        8
`define IFM_CODE_W          6
`define IFM_NUM_FUNC        64

`define IFM_ADR_FSEL_BASE   6'h00
`define IFM_ADR_LOGIC       6'h08
`define IFM_ADR_TERM_STATE  6'h09
`define IFM_ADR_FUNC_LO     6'h0a
`define IFM_ADR_FUNC_HI     6'h0b

`define IFM_FSEL_RST_PACKED {6'h18, 6'h12, 6'h10, 6'h32, 6'h31, 6'h30, 6'h04, 6'h03}
`define IFM_LOGIC_RST       8'h00

`define IFM_FN_EXCITE_CTRL  6'h11
`define IFM_FN_ALARM_RESET  6'h18
`define IFM_FN_POS_PRESET   6'h19
`define IFM_FN_ABS_ERR_CLR  6'h1a
`define IFM_FN_OP_LOCK_REL  6'h1b

`define IFM_FN_MOTION_LO    6'h01
`define IFM_FN_MOTION_HI    6'h0d
`define IFM_FN_STOP_LO      6'h10
`define IFM_FN_STOP_HI      6'h12
`define IFM_FN_RESET_LO     6'h18
`define IFM_FN_RESET_HI     6'h1b
`define IFM_FN_DATA_LO      6'h20
`define IFM_FN_DATA_HI      6'h35

`endif

// ==== core/ifm_pkg.sv ====
// types of the input function mapper
package ifm_pkg;
   typedef logic [5:0]  ifm_code_t;
   typedef logic [63:0] ifm_func_vec_t;
   typedef enum logic [1:0] {IFM_BUS_IDLE, IFM_BUS_FETCH, IFM_BUS_ANSWER} ifm_bus_state_t;
endpackage

// ==== core/ifm_code_store.sv ====
// storage of the per-terminal function codes
`timescale 1ns/10ps
`default_nettype none
`include "ifm_cfg.svh"
module ifm_code_store
   import ifm_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wr_en_i,
   input  wire logic [2:0]  wr_idx_i,
   input  wire ifm_code_t   wr_data_i,
   input  wire logic [2:0]  rd_idx_i,
   output ifm_code_t        rd_data_o,
   output logic [47:0]      codes_o
);
   logic [47:0] codes_ff;
   logic [47:0] nxt_codes;
   ifm_code_t   rd_data_ff;
   ifm_code_t   nxt_rd_data;

   always_comb
   begin
      nxt_codes = codes_ff;
      if (wr_en_i)
      begin
         nxt_codes[wr_idx_i*6 +: 6] = wr_data_i;
      end
      nxt_rd_data = codes_ff[rd_idx_i*6 +: 6];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         codes_ff   <= `IFM_FSEL_RST_PACKED;
         rd_data_ff <= 6'h00;
      end
      else
      begin
         codes_ff   <= nxt_codes;
         rd_data_ff <= nxt_rd_data;
      end
   end

   assign rd_data_o = rd_data_ff;
   assign codes_o   = codes_ff;
endmodule
`default_nettype wire

// ==== core/ifm_input_function_mapper.sv ====
// input function mapper: terminals to internal functions, wishbone setup
//
// Notes on behaviour
// - per-terminal function code, documented reset defaults
// - function code decoded into numbered functions
// - shared function asserted when any terminal active
// - alarm reset, error clear fire active-to-inactive
// - position preset fires inactive-to-active
// - excitation, lock release on when unassigned
// - excitation, lock release: direct plus remote assignment needs both
// - per-terminal logic level, zero normally open
// - remote path is separate function source
`timescale 1ns/10ps
`default_nettype none
`include "ifm_cfg.svh"
module ifm_input_function_mapper
   import ifm_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [7:0]  input_terminal_i,
   input  wire logic [63:0] remote_func_i,
   input  wire logic [63:0] remote_assigned_i,
   output logic [63:0]      func_active_o,
   output logic             alarm_reset_pulse_o,
   output logic             abs_position_error_clear_pulse_o,
   output logic             position_preset_pulse_o
);
   ifm_bus_state_t state_ff;
   ifm_bus_state_t nxt_state;
   logic           ack_ff;
   logic           nxt_ack;
   logic [31:0]    dat_ff;
   logic [31:0]    nxt_dat;
   logic [7:0]     logic_ff;
   logic [7:0]     nxt_logic;
   logic [5:0]     adr_word;
   logic           adr_ok;
   logic           fsel_wr;
   ifm_code_t      fsel_rd;
   logic [47:0]    codes;

   logic [7:0]     active_ff;
   logic [7:0]     nxt_active;
   ifm_func_vec_t  func_ff;
   ifm_func_vec_t  nxt_func;
   logic           alm_ff;
   logic           nxt_alm;
   logic           clr_ff;
   logic           nxt_clr;
   logic           pre_ff;
   logic           nxt_pre;
   ifm_func_vec_t  direct_hit;
   ifm_func_vec_t  direct_asg;
   ifm_func_vec_t  hit_vec [8];
   ifm_func_vec_t  asg_vec [8];

   function automatic logic code_listed(input ifm_code_t c);
      code_listed = (c >= `IFM_FN_MOTION_LO && c <= `IFM_FN_MOTION_HI) ||
                    (c >= `IFM_FN_STOP_LO && c <= `IFM_FN_STOP_HI) ||
                    (c >= `IFM_FN_RESET_LO && c <= `IFM_FN_RESET_HI) ||
                    (c >= `IFM_FN_DATA_LO && c <= `IFM_FN_DATA_HI);
   endfunction

   assign adr_word = wb_adr_i[7:2];
   assign adr_ok   = (wb_adr_i[31:8] == 24'h000000) && (wb_adr_i[1:0] == 2'h0);
   assign fsel_wr  = (state_ff == IFM_BUS_IDLE) && wb_cyc_i && wb_stb_i && wb_we_i &&
                     wb_sel_i[0] && adr_ok && (adr_word[5:3] == 3'h0);

   ifm_code_store u_code_store
   (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .wr_en_i   (fsel_wr),
      .wr_idx_i  (adr_word[2:0]),
      .wr_data_i (wb_dat_i[5:0]),
      .rd_idx_i  (adr_word[2:0]),
      .rd_data_o (fsel_rd),
      .codes_o   (codes)
   );

   // bus slave
   always_comb
   begin
      nxt_state = state_ff;
      nxt_ack   = 1'b0;
      nxt_dat   = dat_ff;
      nxt_logic = logic_ff;
      unique case (state_ff)
         IFM_BUS_IDLE:
         begin
            if (wb_cyc_i && wb_stb_i)
            begin
               nxt_state = IFM_BUS_FETCH;
               if (wb_we_i && wb_sel_i[0] && adr_ok && adr_word == `IFM_ADR_LOGIC)
               begin
                  nxt_logic = wb_dat_i[7:0];
               end
            end
         end
         IFM_BUS_FETCH:
         begin
            nxt_state = IFM_BUS_ANSWER;
            nxt_ack   = 1'b1;
            nxt_dat   = 32'h00000000;
            if (adr_ok && adr_word[5:3] == 3'h0)
            begin
               nxt_dat = {26'h0000000, fsel_rd};
            end
            else if (adr_ok && adr_word == `IFM_ADR_LOGIC)
            begin
               nxt_dat = {24'h000000, logic_ff};
            end
            else if (adr_ok && adr_word == `IFM_ADR_TERM_STATE)
            begin
               nxt_dat = {24'h000000, active_ff};
            end
            else if (adr_ok && adr_word == `IFM_ADR_FUNC_LO)
            begin
               nxt_dat = func_ff[31:0];
            end
            else if (adr_ok && adr_word == `IFM_ADR_FUNC_HI)
            begin
               nxt_dat = func_ff[63:32];
            end
         end
         IFM_BUS_ANSWER:
         begin
            nxt_state = IFM_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_ff <= IFM_BUS_IDLE;
         ack_ff   <= 1'b0;
         dat_ff   <= 32'h00000000;
         logic_ff <= `IFM_LOGIC_RST;
      end
      else
      begin
         state_ff <= nxt_state;
         ack_ff   <= nxt_ack;
         dat_ff   <= nxt_dat;
         logic_ff <= nxt_logic;
      end
   end

   // per-terminal decode
   genvar t;
   generate
      for (t = 0; t < 8; t = t + 1)
      begin : g_term
         logic [5:0] term_code;
         assign term_code  = codes[t*6 +: 6];
         assign asg_vec[t] = code_listed(term_code) ? (64'h1 << term_code) : 64'h0;
         assign hit_vec[t] = active_ff[t] ? asg_vec[t] : 64'h0;
      end
   endgenerate

   always_comb
   begin
      direct_hit = 64'h0;
      direct_asg = 64'h0;
      for (int i = 0; i < 8; i++)
      begin
         direct_hit = direct_hit | hit_vec[i];
         direct_asg = direct_asg | asg_vec[i];
      end
   end

   // function levels and edge pulses
   always_comb
   begin
      ifm_code_t fn_code;
      fn_code    = 6'h00;
      nxt_active = input_terminal_i ^ logic_ff;
      nxt_func   = direct_hit | remote_func_i;
      nxt_func[0] = 1'b0;
      for (int k = 0; k < 2; k++)
      begin
         fn_code = (k == 0) ? `IFM_FN_EXCITE_CTRL : `IFM_FN_OP_LOCK_REL;
         if (!direct_asg[fn_code])
         begin
            nxt_func[fn_code] = 1'b1;
         end
         else if (remote_assigned_i[fn_code])
         begin
            nxt_func[fn_code] = direct_hit[fn_code] & remote_func_i[fn_code];
         end
         else
         begin
            nxt_func[fn_code] = direct_hit[fn_code];
         end
      end
      nxt_alm = func_ff[`IFM_FN_ALARM_RESET] & ~nxt_func[`IFM_FN_ALARM_RESET];
      nxt_clr = func_ff[`IFM_FN_ABS_ERR_CLR] & ~nxt_func[`IFM_FN_ABS_ERR_CLR];
      nxt_pre = ~func_ff[`IFM_FN_POS_PRESET] & nxt_func[`IFM_FN_POS_PRESET];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         active_ff <= 8'h00;
         func_ff   <= 64'h0;
         alm_ff    <= 1'b0;
         clr_ff    <= 1'b0;
         pre_ff    <= 1'b0;
      end
      else
      begin
         active_ff <= nxt_active;
         func_ff   <= nxt_func;
         alm_ff    <= nxt_alm;
         clr_ff    <= nxt_clr;
         pre_ff    <= nxt_pre;
      end
   end

   assign wb_dat_o                         = dat_ff;
   assign wb_ack_o                         = ack_ff;
   assign func_active_o                    = func_ff;
   assign alarm_reset_pulse_o              = alm_ff;
   assign abs_position_error_clear_pulse_o = clr_ff;
   assign position_preset_pulse_o          = pre_ff;
endmodule
`default_nettype wire

// ==== tb/ifm_checker.sv ====
// assertions on the input function mapper ports
`timescale 1ns/10ps
`default_nettype none
module ifm_checker (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic [63:0] remote_func_i,
   input wire logic [63:0] func_active_o,
   input wire logic        alarm_reset_pulse_o,
   input wire logic        abs_position_error_clear_pulse_o,
   input wire logic        position_preset_pulse_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_width_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !$past(wb_cyc_i) |-> ##2 wb_ack_o)
      else $error("ack late");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i, 2))
      else $error("stray ack");
   no_func_a: assert property (!func_active_o[0]) else $error("code 0 active");
   alarm_edge_a: assert property (
      alarm_reset_pulse_o == $fell(func_active_o[24])) else $error("alarm pulse");
   clear_edge_a: assert property (
      abs_position_error_clear_pulse_o == $fell(func_active_o[26])) else $error("clear pulse");
   preset_edge_a: assert property (
      position_preset_pulse_o == $rose(func_active_o[25])) else $error("preset pulse");
   remote_or_a: assert property (
      remote_func_i[32] [*3] |-> func_active_o[32]) else $error("remote lost");
   cover property (alarm_reset_pulse_o);
   cover property (position_preset_pulse_o);
   cover property (wb_ack_o);
endmodule
bind ifm_input_function_mapper ifm_checker u_ifm_checker (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .remote_func_i(remote_func_i), .func_active_o(func_active_o),
   .alarm_reset_pulse_o(alarm_reset_pulse_o), .position_preset_pulse_o(position_preset_pulse_o),
   .abs_position_error_clear_pulse_o(abs_position_error_clear_pulse_o));
`default_nettype wire

// ==== tb/ifm_switch_model.sv ====
// contacts and remote controller in front of the terminals
`timescale 1ns/10ps
`default_nettype none
module ifm_switch_model (
   input  wire logic        clk_i,
   input  wire logic [7:0]  close_i,
   input  wire logic [63:0] remote_i,
   output var  logic [7:0]  input_terminal_o = 8'h00,
   output var  logic [63:0] remote_func_o = 64'h0
);
   always @(posedge clk_i)
   begin
      input_terminal_o <= close_i;
      remote_func_o    <= remote_i;
   end
endmodule
`default_nettype wire

// ==== tb/ifm_input_function_mapper_tb_top.sv ====
// self-checking bench of the input function mapper
`timescale 1ns/10ps
`default_nettype none
module ifm_input_function_mapper_tb_top;
   logic        clk_i;
   logic        rst_i = 1'b1;
   logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, alm, clr, pre;
   logic [31:0] wb_adr = '0, wb_wdat = '0, wb_rdat, rd;
   logic [7:0]  close = '0, term;
   logic [3:0]  wb_sel = 4'h0;
   logic [63:0] rem_set = '0, rem_asg = '0, rem_fn, func;
   int          errors, checks, ticks, n_ev [3], n, c;
   logic [5:0]  dflt [8] = '{6'h03, 6'h04, 6'h30, 6'h31, 6'h32, 6'h10, 6'h12, 6'h18};
   ifm_switch_model u_ifm_switch_model (.clk_i(clk_i), .close_i(close), .remote_i(rem_set),
      .input_terminal_o(term), .remote_func_o(rem_fn));
   ifm_input_function_mapper u_ifm_input_function_mapper (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .input_terminal_i(term), .remote_func_i(rem_fn), .remote_assigned_i(rem_asg),
      .func_active_o(func), .alarm_reset_pulse_o(alm), .position_preset_pulse_o(pre),
      .abs_position_error_clear_pulse_o(clr));
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      ticks++;
      n_ev[0] += int'(alm === 1'b1);
      n_ev[1] += int'(clr === 1'b1);
      n_ev[2] += int'(pre === 1'b1);
      if (ticks == 20000)
      begin
         errors++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wb(logic we, logic [31:0] adr, logic [31:0] dat);
      @(posedge clk_i);
      wb_cyc  <= 1'b1;
      wb_stb  <= 1'b1;
      wb_we   <= we;
      wb_sel  <= 4'h1;
      wb_adr  <= adr;
      wb_wdat <= dat;
      do
      begin
         @(posedge clk_i);
      end
      while (wb_ack !== 1'b1);
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask
   task automatic rdc(string what, logic [31:0] adr, logic [31:0] exp);
      wb(1'b0, adr, 32'h0);
      chk(what, {32'h0, exp}, {32'h0, rd});
   endtask
   task automatic drive(logic [7:0] v, logic [63:0] r);
      @(posedge clk_i);
      close   <= v;
      rem_set <= r;
      repeat (5) @(posedge clk_i);
   endtask
   task automatic evt(int t, logic [7:0] v, int on, int off);
      n = n_ev[t];
      drive(v, '0);
      chk("pulse on", on, n_ev[t] - n);
      drive(8'h00, '0);
      chk("pulse off", on + off, n_ev[t] - n);
   endtask
   initial
   begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      for (c = 0; c < 8; c++)
         rdc("code", 32'(4 * c), {26'h0, dflt[c]});
      rdc("level", 32'h20, 32'h0);
      rdc("unmapped", 32'h40, 32'h0);
      rdc("func low", 32'h28, 32'h08020000);
      rdc("func high", 32'h2c, 32'h0);
      rdc("term state", 32'h24, 32'h0);
      $display("reset values done");
      for (c = 0; c < 64; c++)
      begin
         wb(1'b1, 32'h0, 32'(c));
         drive(8'h01, '0);
         chk("decode", c inside {[1:13], [16:18], [24:27], [32:53]}, func[c]);
         drive(8'h00, '0);
      end
      $display("decode done");
      wb(1'b1, 32'h0, 32'd32);
      wb(1'b1, 32'h4, 32'd32);
      drive(8'h02, '0);
      chk("shared", 1, func[32]);
      drive(8'h00, 64'h1 << 32);
      chk("remote", 1, func[32]);
      wb(1'b1, 32'h20, 32'h1);
      drive(8'h00, '0);
      chk("inverted", 1, func[32]);
      rdc("term state inv", 32'h24, 32'h1);
      rdc("func high inv", 32'h2c, 32'h1);
      wb(1'b1, 32'h20, 32'h0);
      $display("mapping done");
      evt(0, 8'h80, 0, 1);
      wb(1'b1, 32'h0, 32'd26);
      evt(1, 8'h01, 0, 1);
      wb(1'b1, 32'h0, 32'd25);
      evt(2, 8'h01, 1, 0);
      $display("edges done");
      wb(1'b1, 32'h0, 32'd17);
      rem_asg <= 64'h1 << 17;
      drive(8'h01, '0);
      chk("both one", 0, func[17]);
      drive(8'h01, 64'h1 << 17);
      chk("both two", 1, func[17]);
      chk("lock free", 1, func[27]);
      rem_asg <= '0;
      drive(8'h00, 64'h1 << 17);
      chk("assigned open", 0, func[17]);
      $display("excitation done");
      stop_test();
   end
endmodule
`default_nettype wire
